//--- testbench.sv
// Self-checking bench for the panel power sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                          clk_sys, rst, ps, shc, lin, frm;
	logic [tftp_pkg::PIX_W-1:0]    pix, bus;
	logic [tftp_pkg::GPIO_W-1:0]   sw, go;
	logic                          sc, lp, fp, pol, act, met, flt;
	int                            err_count, num_checks;

	tftp_power_seq u_tftp_power_seq (.clk_sys(clk_sys), .rst(rst),
		.power_save_en(ps), .pix_data_in(pix), .shift_clock_in(shc),
		.line_pulse_in(lin), .frame_pulse_in(frm), .gpio_sw(sw),
		.panel_pixel_bus(bus), .pixel_shift_clock(sc), .line_pulse(lp),
		.frame_pulse(fp), .gpio_out(go), .line_polarity_toggle(pol),
		.panel_signals_active(act), .gate_delay_met(met));
	tftp_panel_model u_tftp_panel_model (.clk_sys(clk_sys), .rst(rst),
		.frame_pulse(fp), .gpio_out(go), .seq_fault(flt));

	// ******************************
	// Clock and helpers
	// ******************************
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic chkv(input string nm,
		input logic [tftp_pkg::PIX_W-1:0] e, input logic [tftp_pkg::PIX_W-1:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("Checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic frame_go;
		frm = 1'b1;
		tick(1);
		chk1("frame_out", 1'b1, fp);
		frm = 1'b0;
		tick(1);
	endtask
	task automatic line_go;
		lin = 1'b1;
		tick(1);
		chk1("line_out", 1'b1, lp);
		lin = 1'b0;
		tick(1);
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_wake;
		sw[tftp_pkg::GPIO_LOGIC_SUPPLY] = 1'b1;
		tick(1);
		pix = 18'h2_A5C3;
		sw[3:0] = 4'hA;
		shc = 1'b1;
		ps = 1'b0;
		tick(1);
		chk1("active", 1'b1, act);
		chk1("shift_clk", 1'b1, sc);
		shc = 1'b0;
		chkv("pix_bus", 18'h2_A5C3, bus);
		chkv("gpio_grp", 18'h0_000A, 18'(go[3:0]));
	endtask
	task automatic t_polarity;
		logic s0, p;
		frame_go();
		s0 = pol;
		repeat (2) begin
			p = pol;
			line_go();
			chk1("pol_line", ~p, pol);
		end
		frame_go();
		chk1("pol_frame", ~s0, pol);
	endtask
	task automatic t_gate;
		sw[tftp_pkg::GPIO_OTHER_SUPPLY] = 1'b1;
		tick(3);
		repeat (2) begin
			frame_go();
			repeat (2) line_go();
		end
		chk1("gate_early", 1'b0, met);
		frame_go();
		chk1("gate_met", 1'b1, met);
		sw[tftp_pkg::GPIO_POWER_GATE] = 1'b1;
		tick(2);
	endtask
	task automatic t_sleep;
		logic p;
		sw[tftp_pkg::GPIO_POWER_GATE] = 1'b0;
		tick(1);
		sw[tftp_pkg::GPIO_OTHER_SUPPLY] = 1'b0;
		tick(2);
		chk1("gate_drop", 1'b0, met);
		p = pol;
		{shc, lin, frm} = 3'b111;
		ps = 1'b1;
		tick(1);
		chk1("inactive", 1'b0, act);
		chkv("pix_low", 18'h0_0000, bus);
		chkv("ctl_low", 18'h0_0000, 18'({sc, lp, fp, go[3:0]}));
		chk1("pol_hold", p, pol);
		chk1("logic_pin", 1'b1, go[tftp_pkg::GPIO_LOGIC_SUPPLY]);
		{shc, lin, frm} = 3'b000;
		sw[tftp_pkg::GPIO_LOGIC_SUPPLY] = 1'b0;
		tick(2);
		chk1("seq_fault", 1'b0, flt);
	endtask

	// ******************************
	// Main sequence and watchdog
	// ******************************
	initial begin
		err_count = 0;
		num_checks = 0;
		rst = 1'b1;
		ps = tftp_pkg::PS_RESET_VAL;
		pix = 18'h0_0000;
		{shc, lin, frm} = 3'b000;
		sw = 7'h00;
		repeat (20) @(posedge clk_sys);
		#1 rst = 1'b0;
		tick(2);
		chkv("pix_reset", 18'h0_0000, bus);
		t_wake();
		t_polarity();
		t_gate();
		t_sleep();
		end_of_test();
	end
	initial begin
		#5000;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire

//--- tftp_panel_model.sv
// Panel model watching power-gate and supply sequencing
`timescale 1ns/1ps
`default_nettype none
module tftp_panel_model (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// Panel side pins
	input  wire logic                        frame_pulse,
	input  wire logic [tftp_pkg::GPIO_W-1:0] gpio_out,
	// Sequencing fault seen
	output var  logic                        seq_fault
);
	logic [3:0] frames_reg;
	logic       frame_d_reg;
	logic [1:0] pins_d_reg;
	wire        gate = gpio_out[tftp_pkg::GPIO_POWER_GATE];
	wire        other = gpio_out[tftp_pkg::GPIO_OTHER_SUPPLY];

	// ******************************
	// Frame count and order checks
	// ******************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frames_reg  <= 4'h0;
			frame_d_reg <= 1'b0;
			pins_d_reg  <= 2'b00;
			seq_fault   <= 1'b0;
		end else begin
			frame_d_reg <= frame_pulse;
			pins_d_reg  <= {gate, other};
			if (!other)
				frames_reg <= 4'h0;
			else if (frame_pulse && !frame_d_reg && frames_reg != 4'hF)
				frames_reg <= frames_reg + 4'h1;
			// Gate only after two whole frames
			if (gate && !pins_d_reg[1] && frames_reg < 4'h3)
				seq_fault <= 1'b1;
			if (!other && pins_d_reg[0] && gate)
				seq_fault <= 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- tftp_pkg.sv
// Shared constants of the panel power sequencer
package tftp_pkg;

	// ******************************
	// Widths
	// ******************************
	localparam int PIX_W      = 18;
	localparam int GPIO_W     = 7;
	localparam int GRP_GPIO_W = 4;

	// ******************************
	// Pin assignment of the spare pins
	// ******************************
	localparam int GPIO_OTHER_SUPPLY = 4;
	localparam int GPIO_POWER_GATE   = 5;
	localparam int GPIO_LOGIC_SUPPLY = 6;

	// ******************************
	// Software register holding the power-save bit
	// ******************************
	localparam logic [7:0] PS_REG_INDEX  = 8'hA0;
	localparam logic       PS_RESET_VAL  = 1'b1;

	// ******************************
	// Timing
	// ******************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SIG_T_MAX_NS  = 20;
	// Longest time rounds down
	localparam int SIG_T_CYCLES  = (SIG_T_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int GATE_FRAMES   = 2;
	// Frame starts seen once the wanted periods are complete
	localparam logic [1:0] GATE_EDGES = 2'(GATE_FRAMES + 1);

	// ******************************
	// Counter states
	// ******************************
	typedef enum logic [1:0] {
		TFTP_GATE_IDLE = 2'b00,
		TFTP_GATE_WAIT = 2'b01,
		TFTP_GATE_MET  = 2'b10
	} tftp_gate_e;

endpackage

//--- tftp_polarity.sv
// Line polarity toggle with per-frame alternation
`timescale 1ns/1ps
`default_nettype none
module tftp_polarity (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Sync events
	input  wire logic line_rise,
	input  wire logic frame_rise,
	// Polarity out
	output var  logic line_polarity_toggle
);

	logic start_pol_reg;
	logic start_pol_next;
	logic pol_next;

	// ******************************
	// Next-state selection
	// ******************************
	// Frame start alternates
	assign start_pol_next = frame_rise ? ~start_pol_reg : start_pol_reg;
	assign pol_next = frame_rise ? ~start_pol_reg :
		line_rise ? ~line_polarity_toggle : line_polarity_toggle;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			start_pol_reg        <= 1'b0;
			line_polarity_toggle <= 1'b0;
		end else begin
			start_pol_reg        <= start_pol_next;
			line_polarity_toggle <= pol_next;
		end
	end

	// ******************************
	// Checks
	// ******************************
	a_line_flip: assert property (
		@(posedge clk_sys) disable iff (rst)
		line_rise && !frame_rise |=>
			line_polarity_toggle != $past(line_polarity_toggle))
		else $error("polarity did not flip on line");

	a_frame_alternate: assert property (
		@(posedge clk_sys) disable iff (rst)
		frame_rise |=> line_polarity_toggle == !$past(start_pol_reg)
			&& start_pol_reg != $past(start_pol_reg))
		else $error("frame start polarity did not alternate");

	a_pol_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		!line_rise && !frame_rise |=> $stable(line_polarity_toggle))
		else $error("polarity changed without sync");

endmodule
`default_nettype wire

//--- tftp_power_seq.sv
// Panel signal gating and power sequencing support
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Polarity output flips on every line pulse not at a frame start while power save is off
// - Polarity alternates per line and per frame
// - Drive signals within 20 ns of wake
// - Force signals low within 20 ns
// - Group: pixel bus, clocks, pulses, pins 0-3
// - Power-save enable bit gates the group; other-supply pin starts the gate delay count
module tftp_power_seq (
	// Clock and reset
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	// Power-save bit from the control register
	input  wire logic                             power_save_en,
	// Panel timing from the display pipeline
	input  wire logic [tftp_pkg::PIX_W-1:0]       pix_data_in,
	input  wire logic                             shift_clock_in,
	input  wire logic                             line_pulse_in,
	input  wire logic                             frame_pulse_in,
	// Software levels for the general-purpose pins
	input  wire logic [tftp_pkg::GPIO_W-1:0]      gpio_sw,
	// Panel signal group and spare pins
	output var  logic [tftp_pkg::PIX_W-1:0]       panel_pixel_bus,
	output var  logic                             pixel_shift_clock,
	output var  logic                             line_pulse,
	output var  logic                             frame_pulse,
	output var  logic [tftp_pkg::GPIO_W-1:0]      gpio_out,
	// Polarity and status
	output var  logic                             line_polarity_toggle,
	output var  logic                             panel_signals_active,
	output var  logic                             gate_delay_met
);

	// ******************************
	// Signal gating
	// ******************************
	logic                             drive_en;
	logic [tftp_pkg::PIX_W-1:0]       pix_next;
	logic                             shift_next;
	logic                             line_next;
	logic                             frame_next;
	logic [tftp_pkg::GPIO_W-1:0]      gpio_next;
	logic [tftp_pkg::GRP_GPIO_W-1:0]  grp_gpio;

	assign drive_en = !power_save_en;
	assign pix_next   = drive_en ? pix_data_in : '0;
	assign shift_next = drive_en & shift_clock_in;
	assign line_next  = drive_en & line_pulse_in;
	assign frame_next = drive_en & frame_pulse_in;
	assign grp_gpio   = drive_en ?
		gpio_sw[tftp_pkg::GRP_GPIO_W-1:0] : '0;
	// Spare pins never gated by power save
	assign gpio_next = {gpio_sw[tftp_pkg::GPIO_W-1:tftp_pkg::GRP_GPIO_W],
		grp_gpio};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			panel_pixel_bus      <= '0;
			pixel_shift_clock    <= 1'b0;
			line_pulse           <= 1'b0;
			frame_pulse          <= 1'b0;
			gpio_out             <= '0;
			panel_signals_active <= !tftp_pkg::PS_RESET_VAL;
		end else begin
			panel_pixel_bus      <= pix_next;
			pixel_shift_clock    <= shift_next;
			line_pulse           <= line_next;
			frame_pulse          <= frame_next;
			gpio_out             <= gpio_next;
			panel_signals_active <= drive_en;
		end
	end

	// ******************************
	// Sync edge detection
	// ******************************
	logic line_prev_reg;
	logic frame_prev_reg;
	logic frame_in_prev_reg;
	logic line_rise;
	logic frame_rise;
	logic frame_in_rise;

	assign line_rise     = line_next & ~line_prev_reg;
	assign frame_rise    = frame_next & ~frame_prev_reg;
	assign frame_in_rise = frame_pulse_in & ~frame_in_prev_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			line_prev_reg  <= 1'b0;
			frame_prev_reg <= 1'b0;
		end else begin
			line_prev_reg  <= line_next;
			frame_prev_reg <= frame_next;
		end
	end

	// ******************************
	// Polarity generator
	// ******************************
	tftp_polarity u_polarity (
		.clk_sys              (clk_sys),
		.rst                  (rst),
		.line_rise            (line_rise),
		.frame_rise           (frame_rise),
		.line_polarity_toggle (line_polarity_toggle)
	);

	// ******************************
	// Power-gate delay counter
	// ******************************
	logic                   supply_on;
	logic [1:0]             edge_cnt_reg;
	logic [1:0]             edge_cnt_next;
	tftp_pkg::tftp_gate_e   gate_state_reg;
	tftp_pkg::tftp_gate_e   gate_state_next;

	assign supply_on = gpio_sw[tftp_pkg::GPIO_OTHER_SUPPLY];

	always_comb begin
		gate_state_next = gate_state_reg;
		edge_cnt_next   = edge_cnt_reg;
		case (gate_state_reg)
			tftp_pkg::TFTP_GATE_IDLE: begin
				edge_cnt_next = 2'h0;
				if (supply_on) begin
					gate_state_next = tftp_pkg::TFTP_GATE_WAIT;
				end
			end
			tftp_pkg::TFTP_GATE_WAIT: begin
				if (!supply_on) begin
					gate_state_next = tftp_pkg::TFTP_GATE_IDLE;
				end else if (frame_in_rise) begin
					edge_cnt_next = edge_cnt_reg + 2'h1;
					if (edge_cnt_next == tftp_pkg::GATE_EDGES) begin
						gate_state_next = tftp_pkg::TFTP_GATE_MET;
					end
				end
			end
			tftp_pkg::TFTP_GATE_MET: begin
				if (!supply_on) begin
					gate_state_next = tftp_pkg::TFTP_GATE_IDLE;
				end
			end
			default: begin
				gate_state_next = tftp_pkg::TFTP_GATE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			frame_in_prev_reg <= 1'b0;
			edge_cnt_reg      <= 2'h0;
			gate_state_reg    <= tftp_pkg::TFTP_GATE_IDLE;
			gate_delay_met    <= 1'b0;
		end else begin
			frame_in_prev_reg <= frame_pulse_in;
			edge_cnt_reg      <= edge_cnt_next;
			gate_state_reg    <= gate_state_next;
			// Ready flag for the gate pin
			gate_delay_met    <=
				(gate_state_next == tftp_pkg::TFTP_GATE_MET);
		end
	end

	// ******************************
	// Checks
	// ******************************
	sequence s_wake;
		$fell(power_save_en) ##1 !power_save_en;
	endsequence

	sequence s_sleep;
		$rose(power_save_en) ##1 power_save_en;
	endsequence

	a_wake_drives: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_wake |-> panel_signals_active
			&& panel_pixel_bus == $past(pix_data_in)
			&& line_pulse == $past(line_pulse_in))
		else $error("signals not driven after wake");

	a_sleep_low: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_sleep |-> panel_pixel_bus == '0 && !pixel_shift_clock
			&& !line_pulse && !frame_pulse && !panel_signals_active)
		else $error("signals not low after sleep");

	a_group_pins_low: assert property (
		@(posedge clk_sys) disable iff (rst)
		power_save_en |=> gpio_out[tftp_pkg::GRP_GPIO_W-1:0] == '0)
		else $error("group pins not forced low");

	a_spare_pins_free: assert property (
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> gpio_out[tftp_pkg::GPIO_W-1:tftp_pkg::GRP_GPIO_W] ==
			$past(gpio_sw[tftp_pkg::GPIO_W-1:tftp_pkg::GRP_GPIO_W]))
		else $error("spare pin did not follow software");

	a_ps_controls: assert property (
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> panel_signals_active == !$past(power_save_en))
		else $error("active flag does not follow power save");

	a_gate_wait: assert property (
		@(posedge clk_sys) disable iff (rst)
		$rose(gate_delay_met) |-> $past(supply_on)
			&& $past(edge_cnt_reg) == tftp_pkg::GATE_EDGES - 2'h1
			&& $past(frame_in_rise))
		else $error("gate ready before two frames");

	a_gate_drop: assert property (
		@(posedge clk_sys) disable iff (rst)
		!supply_on |=> !gate_delay_met)
		else $error("gate ready while supply off");

endmodule
`default_nettype wire
